// file: logic/pm_byte_merge.sv
// byte-lane write merge with a mask of writable bits
`timescale 1ns/1ps
module pm_byte_merge
(
    input  wire logic [31:0] old_word,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  strb,
    input  wire logic [31:0] wmask,
    output logic      [31:0] merged
);
    logic [31:0] lane_wdata;

    for (genvar b = 0; b < pm_pkg::BYTES_PER_WRD; b++)
    begin : g_lane
        assign lane_wdata[b*pm_pkg::BYTE_W +: pm_pkg::BYTE_W] = strb[b]
            ? wdata[b*pm_pkg::BYTE_W +: pm_pkg::BYTE_W]
            : old_word[b*pm_pkg::BYTE_W +: pm_pkg::BYTE_W];
    end

    // masked-off bits stay zero so reserved bits never hold a value
    assign merged = lane_wdata & wmask;
endmodule

// file: logic/pm_pin_cell.sv
// one pad: picks gpio or one of three functions and fans the pad back in
`timescale 1ns/1ps
module pm_pin_cell
(
    input  wire logic [1:0] sel,
    input  wire logic       gpio_out,
    input  wire logic       gpio_drive,
    input  wire logic       pad_in,
    input  wire logic [2:0] fn_out,
    input  wire logic [2:0] fn_drive,
    output logic            pad_out,
    output logic            pad_oe_n,
    output logic      [2:0] fn_hit,
    output logic      [2:0] fn_in
);
    logic drive;

    always_comb
    begin
        fn_hit  = 3'h0;
        pad_out = gpio_out;
        drive   = gpio_drive;
        case (sel)
            pm_pkg::PM_SEL_GPIO:
            begin
                pad_out = gpio_out;
                drive   = gpio_drive;
            end
            pm_pkg::PM_SEL_ALT1:
            begin
                fn_hit[0] = 1'b1;
                pad_out   = fn_out[0];
                drive     = fn_drive[0];
            end
            pm_pkg::PM_SEL_ALT2:
            begin
                fn_hit[1] = 1'b1;
                pad_out   = fn_out[1];
                drive     = fn_drive[1];
            end
            pm_pkg::PM_SEL_ALT3:
            begin
                fn_hit[2] = 1'b1;
                pad_out   = fn_out[2];
                drive     = fn_drive[2];
            end
            default:
            begin
                fn_hit  = 3'h0;
                pad_out = gpio_out;
                drive   = gpio_drive;
            end
        endcase
    end

    assign pad_oe_n = ~drive;
    // unselected functions see a quiet zero, not the pad
    assign fn_in    = fn_hit & {3{pad_in}};
endmodule

// file: logic/pm_pin_mux.sv
// port 0 pin function multiplexer with apb select registers
//
// Operation
// - each pin routes to one selected function
// - gpio direction only applies under gpio route
// - pins 11, 14, 15 modem, capture, interrupts
// - pin 12 dsr, match 1.0, can4 receive
// - pin 13 dtr, match 1.1, can4 transmit
// - pin 16 interrupt 0, match/capture 0.2
// - pins 17 to 20 spi1 group
// - pin 21 pulse_width_channel_five, can3 receive, capture 1.3
// - pin 22 can3 transmit, capture/match 0.0
// - pin 23 can2 receive only
// - pin 24 can2 transmit only
// - pin 25 can1 receive only
// - pins 27 to 30 analog, reset analog
// - port1 select bit 2 enables debug port
// - port1 select bit 3 enables trace port
`timescale 1ns/1ps
module pm_pin_mux
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:11] gpio_direction_register,
    input  wire logic [31:11] gpio_output_value,
    output logic      [31:11] gpio_pin_level,
    input  wire logic [31:11] pad_in,
    output logic      [31:11] pad_out,
    output logic      [31:11] pad_oe_n,
    output logic      [21:0] low_pin_select,
    output logic             port1_debug_select,
    output logic             port1_trace_select,
    input  wire logic        uart1_dtr_out,
    input  wire logic [3:0]  timer0_match,
    input  wire logic [3:0]  timer1_match,
    input  wire logic        can2_transmit_output,
    input  wire logic        can3_transmit_output,
    input  wire logic        can4_transmit_output,
    input  wire logic        pulse_width_channel_five,
    input  wire logic        spi1_sck_out,
    input  wire logic        spi1_sck_drive,
    input  wire logic        spi1_miso_out,
    input  wire logic        spi1_miso_drive,
    input  wire logic        spi1_mosi_out,
    input  wire logic        spi1_mosi_drive,
    output logic             uart1_cts_in,
    output logic             uart1_dsr_in,
    output logic             uart1_dcd_in,
    output logic             uart1_ri_in,
    output logic      [3:0]  timer0_capture,
    output logic      [3:0]  timer1_capture,
    output logic             external_interrupt_zero,
    output logic             external_interrupt_one,
    output logic             external_interrupt_two,
    output logic             external_interrupt_three,
    output logic             can1_receive_input,
    output logic             can2_receive_input,
    output logic             can3_receive_input,
    output logic             can4_receive_input,
    output logic             spi1_sck_in,
    output logic             spi1_miso_in,
    output logic             spi1_mosi_in,
    output logic             spi1_ssel_in,
    output logic             analog_input_zero,
    output logic             analog_input_one,
    output logic             analog_input_two,
    output logic             analog_input_three
);

    logic [31:0] low_sel_q;
    logic [31:0] high_sel_q;
    logic [31:0] p1_sel_q;
    logic [31:0] prdata_q;
    logic [31:0] merged;
    logic [31:0] old_word;
    logic [31:0] wmask;
    logic [31:0] route_sts;
    logic [31:11] gpio_level_q;
    logic        setup_ph;
    logic        access_ph;
    logic        hit_low;
    logic        hit_high;
    logic        hit_p1;
    logic        hit_sts;
    logic        mapped;
    logic        wr_low;
    logic        wr_high;
    logic        wr_p1;

    logic [1:0]  pin_sel  [31:11];
    logic [2:0]  fn_out   [31:11];
    logic [2:0]  fn_drive [31:11];
    logic [2:0]  fn_hit   [31:11];
    logic [2:0]  fn_in    [31:11];

    // ---------------- apb slave ----------------

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign hit_low   = (paddr == pm_pkg::ADDR_LOW_SEL);
    assign hit_high  = (paddr == pm_pkg::ADDR_HIGH_SEL);
    assign hit_p1    = (paddr == pm_pkg::ADDR_P1_SEL);
    assign hit_sts   = (paddr == pm_pkg::ADDR_ROUTE_STS);
    assign mapped    = hit_low | hit_high | hit_p1 | hit_sts;

    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = access_ph & ~mapped;
    assign prdata  = prdata_q;

    assign wr_low  = access_ph & pwrite & hit_low;
    assign wr_high = access_ph & pwrite & hit_high;
    assign wr_p1   = access_ph & pwrite & hit_p1;

    always_comb
    begin
        old_word = low_sel_q;
        wmask    = pm_pkg::ALL_ONES;
        if (hit_high)
        begin
            old_word = high_sel_q;
        end
        else if (hit_p1)
        begin
            old_word = p1_sel_q;
            wmask    = pm_pkg::P1_WRITE_MASK;
        end
    end

    pm_byte_merge u_merge
    (
        .old_word (old_word),
        .wdata    (pwdata),
        .strb     (pstrb),
        .wmask    (wmask),
        .merged   (merged)
    );

    // all-reserved fields of pins 26 and 31 are stored like any other
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            low_sel_q <= pm_pkg::RST_LOW_SEL;
        end
        else if (wr_low)
        begin
            low_sel_q <= merged;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            high_sel_q <= pm_pkg::RST_HIGH_SEL;
        end
        else if (wr_high)
        begin
            high_sel_q <= merged;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p1_sel_q <= pm_pkg::RST_P1_SEL;
        end
        else if (wr_p1)
        begin
            p1_sel_q <= merged;
        end
    end

    // read data sampled in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= pm_pkg::ZERO_WORD;
        end
        else if (setup_ph)
        begin
            if (hit_low)
            begin
                prdata_q <= low_sel_q;
            end
            else if (hit_high)
            begin
                prdata_q <= high_sel_q;
            end
            else if (hit_p1)
            begin
                prdata_q <= p1_sel_q;
            end
            else if (hit_sts)
            begin
                prdata_q <= route_sts;
            end
            else
            begin
                prdata_q <= pm_pkg::ZERO_WORD;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gpio_level_q <= '0;
        end
        else
        begin
            gpio_level_q <= pad_in;
        end
    end

    assign gpio_pin_level     = gpio_level_q;
    assign low_pin_select     = low_sel_q[pm_pkg::LOW_EXT_W-1:0];
    assign port1_debug_select = p1_sel_q[pm_pkg::P1_DEBUG_BIT];
    assign port1_trace_select = p1_sel_q[pm_pkg::P1_TRACE_BIT];

    // ---------------- function table ----------------
    // index 0/1/2 of each entry is setting 01/10/11; inputs leave drive low

    always_comb
    begin
        for (int p = pm_pkg::FIRST_PIN; p <= pm_pkg::LAST_PIN; p++)
        begin
            fn_out[p]   = 3'h0;
            fn_drive[p] = 3'h0;
        end
        fn_out[12]   = {1'b0, timer1_match[0], 1'b0};
        fn_drive[12] = 3'h2;
        fn_out[13]   = {can4_transmit_output, timer1_match[1], uart1_dtr_out};
        fn_drive[13] = 3'h7;
        fn_out[16]   = {1'b0, timer0_match[2], 1'b0};
        fn_drive[16] = 3'h2;
        fn_out[17]   = {timer1_match[2], spi1_sck_out, 1'b0};
        fn_drive[17] = {1'b1, spi1_sck_drive, 1'b0};
        fn_out[18]   = {timer1_match[3], spi1_miso_out, 1'b0};
        fn_drive[18] = {1'b1, spi1_miso_drive, 1'b0};
        fn_out[19]   = {1'b0, spi1_mosi_out, timer1_match[2]};
        fn_drive[19] = {1'b0, spi1_mosi_drive, 1'b1};
        fn_out[20]   = {2'h0, timer1_match[3]};
        fn_drive[20] = 3'h1;
        fn_out[21]   = {2'h0, pulse_width_channel_five};
        fn_drive[21] = 3'h1;
        fn_out[22]   = {timer0_match[0], 1'b0, can3_transmit_output};
        fn_drive[22] = 3'h5;
        fn_out[24]   = {2'h0, can2_transmit_output};
        fn_drive[24] = 3'h1;
        fn_out[27]   = {timer0_match[1], 2'h0};
        fn_drive[27] = 3'h4;
        fn_out[28]   = {timer0_match[2], 2'h0};
        fn_drive[28] = 3'h4;
        fn_out[29]   = {timer0_match[3], 2'h0};
        fn_drive[29] = 3'h4;
    end

    // ---------------- per-pin cells ----------------
    // each cell reads only its own field, so rewriting a register
    // with unchanged fields leaves those pads untouched

    for (genvar i = pm_pkg::FIRST_PIN; i <= pm_pkg::LAST_PIN; i++)
    begin : g_pin
        if (i == pm_pkg::RSV_PIN_A || i == pm_pkg::RSV_PIN_B)
        begin : g_rsv
            assign pin_sel[i] = pm_pkg::PM_SEL_GPIO;
        end
        else if (i < pm_pkg::PINS_PER_REG)
        begin : g_low
            assign pin_sel[i] = low_sel_q[pm_pkg::FIELD_W*i +: pm_pkg::FIELD_W];
        end
        else
        begin : g_high
            assign pin_sel[i] =
                high_sel_q[pm_pkg::FIELD_W*(i-pm_pkg::PINS_PER_REG) +: pm_pkg::FIELD_W];
        end

        pm_pin_cell u_cell
        (
            .sel        (pin_sel[i]),
            .gpio_out   (gpio_output_value[i]),
            .gpio_drive (gpio_direction_register[i]),
            .pad_in     (pad_in[i]),
            .fn_out     (fn_out[i]),
            .fn_drive   (fn_drive[i]),
            .pad_out    (pad_out[i]),
            .pad_oe_n   (pad_oe_n[i]),
            .fn_hit     (fn_hit[i]),
            .fn_in      (fn_in[i])
        );

        assign route_sts[i] = |fn_hit[i];
    end

    // bit n set when port 0 pin n, 11 to 31, is on a peripheral route; bits 0 to 10 read zero
    assign route_sts[pm_pkg::FIRST_PIN-1:0] = '0;

    // ---------------- inputs back to peripherals ----------------
    // where two pins serve one input they are or-ed, so either may be used

    assign uart1_cts_in = fn_in[11][0];
    assign uart1_dsr_in = fn_in[12][0];
    assign uart1_dcd_in = fn_in[14][0];
    assign uart1_ri_in  = fn_in[15][0];

    assign timer0_capture[0] = fn_in[22][1] | fn_in[30][2];
    assign timer0_capture[1] = fn_in[27][1];
    assign timer0_capture[2] = fn_in[16][2] | fn_in[28][1];
    assign timer0_capture[3] = fn_in[29][1];

    // capture 1.0 lives on pin 10, routed outside this block
    assign timer1_capture[0] = 1'b0;
    assign timer1_capture[1] = fn_in[11][1];
    assign timer1_capture[2] = fn_in[17][0] | fn_in[19][2];
    assign timer1_capture[3] = fn_in[18][0] | fn_in[21][2];

    assign external_interrupt_zero  = fn_in[16][0];
    assign external_interrupt_one   = fn_in[14][1];
    assign external_interrupt_two   = fn_in[15][1];
    assign external_interrupt_three = fn_in[20][2] | fn_in[30][1];

    assign can1_receive_input = fn_in[25][0];
    assign can2_receive_input = fn_in[23][0];
    assign can3_receive_input = fn_in[21][1];
    assign can4_receive_input = fn_in[12][2];

    assign spi1_sck_in  = fn_in[17][1];
    assign spi1_miso_in = fn_in[18][1];
    assign spi1_mosi_in = fn_in[19][1];
    assign spi1_ssel_in = fn_in[20][1];

    // analog routes are levels telling the converter its pad is connected
    assign analog_input_zero  = fn_hit[27][0];
    assign analog_input_one   = fn_hit[28][0];
    assign analog_input_two   = fn_hit[29][0];
    assign analog_input_three = fn_hit[30][0];

endmodule

// file: logic/pm_pkg.sv
// constants and types shared by the port 0 pin function multiplexer
package pm_pkg;

    // register byte addresses
    localparam logic [31:0] ADDR_LOW_SEL   = 32'hE002_C000;
    localparam logic [31:0] ADDR_HIGH_SEL  = 32'hE002_C004;
    localparam logic [31:0] ADDR_P1_SEL    = 32'hE002_C014;
    localparam logic [31:0] ADDR_ROUTE_STS = 32'hE002_C01C;

    // reset values: pins 27..30 come up on their analog route
    localparam logic [31:0] RST_LOW_SEL  = 32'h0000_0000;
    localparam logic [31:0] RST_HIGH_SEL = 32'h1540_0000;
    localparam logic [31:0] RST_P1_SEL   = 32'h0000_0000;

    // port 1 select layout; everything else there is reserved and reads zero
    localparam logic [31:0] P1_WRITE_MASK = 32'h0000_000C;
    localparam logic [31:0] ALL_ONES      = 32'hFFFF_FFFF;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
    localparam int          P1_DEBUG_BIT  = 2;
    localparam int          P1_TRACE_BIT  = 3;

    // field geometry
    localparam int FIELD_W       = 2;
    localparam int PINS_PER_REG  = 16;
    localparam int FIRST_PIN     = 11;
    localparam int LAST_PIN      = 31;
    localparam int LOW_EXT_W     = 22;
    localparam int RSV_PIN_A     = 26;
    localparam int RSV_PIN_B     = 31;
    localparam int BYTE_W        = 8;
    localparam int BYTES_PER_WRD = 4;

    typedef enum logic [1:0]
    {
        PM_SEL_GPIO = 2'h0,
        PM_SEL_ALT1 = 2'h1,
        PM_SEL_ALT2 = 2'h2,
        PM_SEL_ALT3 = 2'h3
    } pm_sel_t;

endpackage

// file: testbench/pm_mux_props.sv
// assertion checker for the port 0 pin function multiplexer
`timescale 1ns/1ps
module pm_mux_props
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [31:0]  paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [3:0]   pstrb,
    input wire logic [31:0]  prdata,
    input wire logic [31:11] gpio_direction_register,
    input wire logic [31:11] gpio_pin_level,
    input wire logic [31:11] pad_in,
    input wire logic [31:11] pad_out,
    input wire logic [31:11] pad_oe_n,
    input wire logic [21:0]  low_pin_select,
    input wire logic         port1_debug_select,
    input wire logic         port1_trace_select,
    input wire logic         pulse_width_channel_five,
    input wire logic         analog_input_zero
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [31:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    property p_debug_bit;
        s_wr(pm_pkg::ADDR_P1_SEL) ##0 pstrb[0] |=> port1_debug_select == $past(pwdata[2]);
    endproperty
    a_debug_bit: assert property (p_debug_bit) else $error("debug select wrong");

    property p_trace_bit;
        s_wr(pm_pkg::ADDR_P1_SEL) ##0 pstrb[0] |=> port1_trace_select == $past(pwdata[3]);
    endproperty
    a_trace_bit: assert property (p_trace_bit) else $error("trace select wrong");

    property p_p1_zero;
        psel && !penable && !pwrite && paddr == pm_pkg::ADDR_P1_SEL
            |=> prdata[1:0] == 2'h0 && prdata[31:4] == 28'h0;
    endproperty
    a_p1_zero: assert property (p_p1_zero) else $error("port1 reserved bits set");

    property p_low_store;
        s_wr(pm_pkg::ADDR_LOW_SEL) ##0 pstrb == 4'hF |=> low_pin_select == $past(pwdata[21:0]);
    endproperty
    a_low_store: assert property (p_low_store) else $error("low select not stored");

    property p_pwm_route;
        s_wr(pm_pkg::ADDR_HIGH_SEL) ##0 pstrb[1] && pwdata[11:10] == 2'h1
            |=> !pad_oe_n[21] && pad_out[21] == pulse_width_channel_five;
    endproperty
    a_pwm_route: assert property (p_pwm_route) else $error("pwm pin not routed");

    property p_analog_sel;
        s_wr(pm_pkg::ADDR_HIGH_SEL) ##0 pstrb[2]
            |=> analog_input_zero == ($past(pwdata[23:22]) == 2'h1);
    endproperty
    a_analog_sel: assert property (p_analog_sel) else $error("analog select wrong");

    property p_analog_hiz;
        analog_input_zero |-> pad_oe_n[27];
    endproperty
    a_analog_hiz: assert property (p_analog_hiz) else $error("analog pin driven");

    property p_rsvd_pins;
        pad_oe_n[26] == !gpio_direction_register[26]
            && pad_oe_n[31] == !gpio_direction_register[31];
    endproperty
    a_rsvd_pins: assert property (p_rsvd_pins) else $error("reserved pin routed");

    property p_pin_sample;
        $past(presetn) |-> gpio_pin_level == $past(pad_in);
    endproperty
    a_pin_sample: assert property (p_pin_sample) else $error("pin level stale");
endmodule

// file: testbench/pm_periph_model.sv
// far side: peripherals driven from a free-running counter and pads with an outside level
`timescale 1ns/1ps
module pm_periph_model
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [31:11] ext_level,
    input  wire logic [31:11] pad_out,
    input  wire logic [31:11] pad_oe_n,
    output logic      [31:11] pad_in,
    output logic              uart1_dtr_out,
    output logic      [3:0]   timer0_match,
    output logic      [3:0]   timer1_match,
    output logic              can2_transmit_output,
    output logic              can3_transmit_output,
    output logic              can4_transmit_output,
    output logic              pulse_width_channel_five,
    output logic              spi1_sck_out,
    output logic              spi1_sck_drive,
    output logic              spi1_miso_out,
    output logic              spi1_miso_drive,
    output logic              spi1_mosi_out,
    output logic              spi1_mosi_drive
);
    logic [7:0] cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_q + 8'h01;
    end

    // a driven pad shows the chip's value, else whatever the board puts on it
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_level);
    // outputs other than spi1_sck_drive follow counter bits, some sharing one, e.g. uart1_dtr_out and pulse_width_channel_five both on bit 0
    assign uart1_dtr_out = cnt_q[0];
    assign timer0_match = cnt_q[3:0];
    assign timer1_match = cnt_q[4:1];
    assign can2_transmit_output = cnt_q[1];
    assign can3_transmit_output = cnt_q[2];
    assign can4_transmit_output = cnt_q[3];
    assign pulse_width_channel_five = cnt_q[0];
    assign spi1_sck_out = cnt_q[5];
    assign spi1_sck_drive = 1'b1;
    assign spi1_miso_out = cnt_q[6];
    assign spi1_miso_drive = cnt_q[4];
    assign spi1_mosi_out = cnt_q[7];
    assign spi1_mosi_drive = cnt_q[2];
endmodule

// file: testbench/port0_pin_function_mux_test.sv
// register-level tests of the port 0 pin function multiplexer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module port0_pin_function_mux_test;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [31:0]  paddr, pwdata, prdata, rd;
    logic [3:0]   pstrb, timer0_match, timer1_match, timer0_capture, timer1_capture;
    logic [31:11] gpio_direction_register, gpio_output_value, gpio_pin_level;
    logic [31:11] pad_in, pad_out, pad_oe_n, ext_level;
    logic [21:0]  low_pin_select;
    logic         port1_debug_select, port1_trace_select, uart1_dtr_out;
    logic         can2_transmit_output, can3_transmit_output, can4_transmit_output;
    logic         pulse_width_channel_five, spi1_sck_out, spi1_sck_drive, spi1_miso_out;
    logic         spi1_miso_drive, spi1_mosi_out, spi1_mosi_drive, uart1_cts_in;
    logic         uart1_dsr_in, uart1_dcd_in, uart1_ri_in, external_interrupt_zero;
    logic         external_interrupt_one, external_interrupt_two, external_interrupt_three;
    logic         can1_receive_input, can2_receive_input, can3_receive_input;
    logic         can4_receive_input, spi1_sck_in, spi1_miso_in, spi1_mosi_in, spi1_ssel_in;
    logic         analog_input_zero, analog_input_one, analog_input_two, analog_input_three;
    int           error_cnt;
    int           samples_checked;
    localparam logic [31:11] DIR_V = 21'h15_5555;
    localparam logic [31:11] OUT_V = 21'h0A_AAAA;

    pm_pin_mux DUT (.*);
    pm_periph_model u_far (.*);

    always #5 pclk = ~pclk;

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [31:0] a, d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // settle one step so checks see the cycle after the write edge
    task automatic wr(input logic [31:0] a, d, input logic [3:0] s);
        xfer(1'b1, a, d, s);
        #1;
    endtask

    task automatic rd_chk(input logic [31:0] a, e);
        xfer(1'b0, a, 32'h0000_0000, 4'h0);
        `CHK("rdata", e, rd);
    endtask

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        gpio_direction_register = '0;
        gpio_output_value = '0;
        ext_level = '1;
        error_cnt = 0;
        samples_checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        `CHK("analog", 4'hF, {analog_input_three, analog_input_two, analog_input_one,
                              analog_input_zero});
        `CHK("analog_oe", 4'hF, pad_oe_n[30:27]);
        rd_chk(pm_pkg::ADDR_HIGH_SEL, 32'h1540_0000);
        rd_chk(pm_pkg::ADDR_LOW_SEL, 32'h0000_0000);
        rd_chk(pm_pkg::ADDR_P1_SEL, 32'h0000_0000);
        wr(pm_pkg::ADDR_P1_SEL, 32'hFFFF_FFFF, 4'hF);
        `CHK("p1_sel", 2'h3, {port1_trace_select, port1_debug_select});
        rd_chk(pm_pkg::ADDR_P1_SEL, 32'h0000_000C);
        wr(pm_pkg::ADDR_P1_SEL, 32'h0000_0004, 4'hF);
        `CHK("p1_sel", 2'h1, {port1_trace_select, port1_debug_select});
        xfer(1'b0, 32'hE002_C008, 32'h0000_0000, 4'h0);
        `CHK("unmapped", 33'h1_0000_0000, {er, rd});
        // peripherals are mapped before their activity is looked at
        wr(pm_pkg::ADDR_LOW_SEL, 32'h6F4A_BCDE, 4'hF);
        `CHK("low_in", 5'h1B, {uart1_cts_in, can4_receive_input, uart1_dsr_in,
                               external_interrupt_one, uart1_ri_in});
        `CHK("can4_tx", {1'b0, can4_transmit_output}, {pad_oe_n[13], pad_out[13]});
        `CHK("low_keep", 22'h0A_BCDE, low_pin_select);
        rd_chk(pm_pkg::ADDR_LOW_SEL, 32'h6F4A_BCDE);
        wr(pm_pkg::ADDR_LOW_SEL, 32'h9F8A_BCDE, 4'hF);
        `CHK("low_in2", 4'h7, {uart1_cts_in, timer1_capture[1], external_interrupt_two,
                               uart1_dcd_in});
        wr(pm_pkg::ADDR_LOW_SEL, 32'h0000_0000, 4'h8);
        rd_chk(pm_pkg::ADDR_LOW_SEL, 32'h008A_BCDE);
        wr(pm_pkg::ADDR_LOW_SEL, 32'h0400_0000, 4'hF);
        `CHK("dtr", {1'b0, uart1_dtr_out}, {pad_oe_n[13], pad_out[13]});
        wr(pm_pkg::ADDR_LOW_SEL, 32'h0A00_0000, 4'hF);
        `CHK("t1_match", timer1_match[1:0], pad_out[13:12]);
        wr(pm_pkg::ADDR_HIGH_SEL, 32'hD575_56A9, 4'hF);
        `CHK("high_in", 4'hF, {external_interrupt_zero, spi1_ssel_in, can2_receive_input,
                               can1_receive_input});
        `CHK("spi_oe", {~spi1_miso_drive, ~spi1_sck_drive}, pad_oe_n[18:17]);
        // an undriven spi pad floats to the board's high level
        `CHK("spi_in", {spi1_mosi_out | ~spi1_mosi_drive, spi1_miso_out | ~spi1_miso_drive,
             spi1_sck_out}, {spi1_mosi_in, spi1_miso_in, spi1_sck_in});
        `CHK("can_tx", {can2_transmit_output, can3_transmit_output, pulse_width_channel_five},
             {pad_out[24], pad_out[22:21]});
        `CHK("rsvd_oe", ~gpio_direction_register[26], pad_oe_n[26]);
        rd_chk(pm_pkg::ADDR_HIGH_SEL, 32'hD575_56A9);
        wr(pm_pkg::ADDR_HIGH_SEL, 32'h2A80_2BD7, 4'hF);
        `CHK("cap0", 4'hF, timer0_capture);
        `CHK("high_in2", 5'h1C, {timer1_capture[3:2], can3_receive_input,
                                 can2_receive_input, can1_receive_input});
        `CHK("analog_off", 2'h1, {analog_input_zero, external_interrupt_three});
        @(posedge pclk);
        ext_level <= '0;
        #1;
        `CHK("cap0_low", 4'h0, timer0_capture);
        wr(pm_pkg::ADDR_HIGH_SEL, 32'h3FC0_3D7E, 4'hF);
        `CHK("match_pins", {timer1_match[3:2], timer1_match[3:2], timer0_match[2]},
             pad_out[20:16]);
        `CHK("match_hi", timer0_match[3:0], {pad_out[29:27], pad_out[22]});
        `CHK("oe_mix", 7'h20, pad_oe_n[22:16]);
        @(posedge pclk);
        ext_level <= '1;
        gpio_direction_register <= DIR_V;
        gpio_output_value <= OUT_V;
        #1;
        `CHK("cap_in", 2'h3, {timer0_capture[0], timer1_capture[3]});
        wr(pm_pkg::ADDR_HIGH_SEL, 32'h0000_0000, 4'hF);
        `CHK("gpio_oe", {~DIR_V[31:14], 2'b00, ~DIR_V[11]}, pad_oe_n);
        `CHK("gpio_out", OUT_V[31:14] & DIR_V[31:14], pad_out[31:14] & DIR_V[31:14]);
        @(posedge pclk);
        #1;
        `CHK("pin_level", (OUT_V[31:14] & DIR_V[31:14]) | ~DIR_V[31:14],
             gpio_pin_level[31:14]);
        print_verdict();
    end

    initial
    begin
        #20000;
        error_cnt++;
        print_verdict();
    end
endmodule

bind pm_pin_mux pm_mux_props u_props (.*);
